// [hw/mos_output_stage.sv]
// measured value routing, error hold, decimation, switching and analog scaling
// Behaviour
// RULE1 - selector picks none, serial, network, analog, switching
// RULE2 - switching choice drives status onto switch outputs
// RULE3 - decimation only on enabled interfaces
// RULE4 - reduced interfaces emit every n-th value
// RULE5 - hold none outputs error value at once
// RULE6 - hold infinite repeats last good value
// RULE7 - numeric hold repeats then error value
// RULE8 - network always carries distance one, thickness extras
// RULE9 - multilayer adds difference dependencies to network
// RULE10 - per-interface signal list, queried in order
// RULE11 - switch on intensity, range or either error
// RULE12 - switch on below, above or outside limits
// RULE13 - host selects signal compared to limits
// RULE14 - compare direction gates shortfall and exceedance
// RULE15 - stored lower and upper thresholds used
// RULE16 - open styles drive while switch active, float otherwise
// RULE17 - totem styles drive both levels, normal or inverted
// RULE18 - host selects analog output signal
// RULE19 - analog span 0-5V, 0-10V or 4-20mA
// RULE20 - scaling mode standard or two-point
// RULE21 - standard scaling uses measuring span
// RULE22 - two-point bounds clamped, three decimals
// RULE23 - counters restart on reset or rewrite
`timescale 1ns/1ps
module mos_output_stage (
  // clock and reset
  input  wire  logic                                 clk_sys,
  input  wire  logic                                 rst,
  // register port
  input  wire  mos_pkg::mos_req_s                    bus_req,
  output logic [31:0]                                bus_rdata,
  // measured values
  input  wire  logic                                 meas_valid,
  input  wire  mos_pkg::mos_frame_s                  meas_frame,
  input  wire  logic                                 thickness_mode,
  input  wire  logic                                 multilayer_mode,
  input  wire  mos_pkg::mos_mask_t [mos_pkg::NSIG-1:0] diff_depend,
  // serial path
  output logic                                       ser_valid,
  output mos_pkg::mos_frame_s                        ser_frame,
  output mos_pkg::mos_mask_t                         ser_mask,
  // network path
  output logic                                       net_valid,
  output mos_pkg::mos_frame_s                        net_frame,
  output mos_pkg::mos_mask_t                         net_mask,
  // analog path
  output logic                                       dac_valid,
  output logic [15:0]                                dac_code,
  output logic [1:0]                                 dac_span,
  // switching pins
  output logic [1:0]                                 sw_out,
  output logic [1:0]                                 sw_oe
);
  localparam int NSIG = mos_pkg::NSIG;

  logic [2:0]               out_sel;
  logic [2:0]               dec_en;
  logic [21:0]              dec_div;
  logic [1:0]               hold_mode;
  logic [10:0]              hold_n;
  logic [31:0]              sw_cfg;
  logic signed [31:0]       lim_lo;
  logic signed [31:0]       lim_hi;
  logic [31:0]              dac_cfg;
  logic signed [31:0]       dac_min;
  logic signed [31:0]       dac_max;
  logic signed [31:0]       span;
  mos_pkg::mos_mask_t       ser_sel;
  mos_pkg::mos_mask_t       net_sel;
  mos_pkg::mos_mask_t       net_eff;
  logic [21:0]              dec_cnt;
  logic [10:0]              hold_cnt;
  logic [NSIG-1:0][31:0]    last_good;
  logic                     held_stb;
  mos_pkg::mos_frame_s      held_frame;
  logic [1:0]               sw_active;
  logic                     meas_err;
  logic                     dec_hit;
  logic                     pass_ser;
  logic                     pass_net;
  logic                     pass_ana;
  logic                     below_hit;
  logic                     above_hit;
  logic signed [31:0]       cmp_v;
  logic [15:0]              next_dac_code;

  function automatic logic signed [31:0] clamp_bound(input logic [31:0] v);
    logic signed [31:0] s;
    s = $signed(v);
    if (s > $signed(mos_pkg::BOUND_MAX)) return $signed(mos_pkg::BOUND_MAX);
    if (s < -$signed(mos_pkg::BOUND_MAX)) return -$signed(mos_pkg::BOUND_MAX);
    return s;
  endfunction : clamp_bound

  function automatic logic [31:0] seq_list(input mos_pkg::mos_mask_t m);
    logic [31:0] r;
    logic [3:0]  k;
    r = '1;
    k = 4'h0;
    for (int i = 0; i < NSIG; i++) begin
      if (m[i]) begin
        r[k*4 +: 4] = 4'(i);
        k = k + 4'h1;
      end
    end
    return r;
  endfunction : seq_list

  // register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_sel   <= mos_pkg::OUT_NONE;
      dec_en    <= 3'h0;
      dec_div   <= mos_pkg::DIV_RST;
      hold_mode <= mos_pkg::HOLD_NONE;
      hold_n    <= 11'h000;
      sw_cfg    <= 32'h00000000;
      lim_lo    <= 32'sh00000000;
      lim_hi    <= 32'sh00000000;
      dac_cfg   <= 32'h00000000;
      dac_min   <= 32'sh00000000;
      dac_max   <= $signed(mos_pkg::DMAX_RST);
      span      <= $signed(mos_pkg::SPAN_RST);
      ser_sel   <= '0;
      net_sel   <= '0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        mos_pkg::ADDR_OUT_SEL: begin
          if (bus_req.wdata[2:0] <= mos_pkg::OUT_SW) out_sel <= bus_req.wdata[2:0]; // see RULE1
        end
        mos_pkg::ADDR_DEC_EN:  dec_en <= bus_req.wdata[2:0]; // see RULE3
        mos_pkg::ADDR_DEC_DIV: begin
          if (bus_req.wdata == 32'h0) dec_div <= mos_pkg::DIV_RST; // see RULE4
          else if (bus_req.wdata > 32'(mos_pkg::DIV_MAX)) dec_div <= mos_pkg::DIV_MAX;
          else dec_div <= bus_req.wdata[21:0];
        end
        mos_pkg::ADDR_HOLD: begin
          hold_mode <= bus_req.wdata[mos_pkg::HOLD_MODE_LSB +: 2];
          if (bus_req.wdata[10:0] > mos_pkg::HOLD_MAX) hold_n <= mos_pkg::HOLD_MAX; // see RULE7
          else hold_n <= bus_req.wdata[10:0];
        end
        mos_pkg::ADDR_SW_CFG:  sw_cfg <= bus_req.wdata;
        mos_pkg::ADDR_LIM_LO:  lim_lo <= $signed(bus_req.wdata); // see RULE15
        mos_pkg::ADDR_LIM_HI:  lim_hi <= $signed(bus_req.wdata); // see RULE15
        mos_pkg::ADDR_DAC_CFG: dac_cfg <= bus_req.wdata;
        mos_pkg::ADDR_DAC_MIN: dac_min <= clamp_bound(bus_req.wdata); // see RULE22
        mos_pkg::ADDR_DAC_MAX: dac_max <= clamp_bound(bus_req.wdata); // see RULE22
        mos_pkg::ADDR_SPAN:    span <= $signed(bus_req.wdata);
        mos_pkg::ADDR_SER_SEL: ser_sel <= bus_req.wdata[NSIG-1:0]; // see RULE10
        mos_pkg::ADDR_NET_SEL: net_sel <= bus_req.wdata[NSIG-1:0]; // see RULE10
        default: ;
      endcase
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        mos_pkg::ADDR_OUT_SEL: bus_rdata <= {29'h0, out_sel};
        mos_pkg::ADDR_DEC_EN:  bus_rdata <= {29'h0, dec_en};
        mos_pkg::ADDR_DEC_DIV: bus_rdata <= {10'h0, dec_div};
        mos_pkg::ADDR_HOLD:    bus_rdata <= {14'h0, hold_mode, 5'h0, hold_n};
        mos_pkg::ADDR_SW_CFG:  bus_rdata <= sw_cfg;
        mos_pkg::ADDR_LIM_LO:  bus_rdata <= lim_lo;
        mos_pkg::ADDR_LIM_HI:  bus_rdata <= lim_hi;
        mos_pkg::ADDR_DAC_CFG: bus_rdata <= dac_cfg;
        mos_pkg::ADDR_DAC_MIN: bus_rdata <= dac_min;
        mos_pkg::ADDR_DAC_MAX: bus_rdata <= dac_max;
        mos_pkg::ADDR_SPAN:    bus_rdata <= span;
        mos_pkg::ADDR_SER_SEL: bus_rdata <= {24'h0, ser_sel};
        mos_pkg::ADDR_NET_SEL: bus_rdata <= {24'h0, net_sel};
        mos_pkg::ADDR_SER_SEQ: bus_rdata <= seq_list(ser_sel); // see RULE10
        mos_pkg::ADDR_NET_SEQ: bus_rdata <= seq_list(net_eff); // see RULE10
        mos_pkg::ADDR_STATUS:  bus_rdata <= {14'h0, sw_active, 5'h0, hold_cnt};
        default:               bus_rdata <= 32'h00000000;
      endcase
    end
  end

  // error hold stage
  assign meas_err = meas_frame.intensity_err | meas_frame.range_err;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      held_stb   <= 1'b0;
      held_frame <= '0;
      last_good  <= '0;
      hold_cnt   <= 11'h000; // see RULE23
    end else begin
      held_stb <= meas_valid;
      if (meas_valid) begin
        if (!meas_err) begin
          held_frame <= meas_frame;
          last_good  <= meas_frame.val;
          hold_cnt   <= 11'h000;
        end else begin
          held_frame.intensity_err <= meas_frame.intensity_err;
          held_frame.range_err     <= meas_frame.range_err;
          held_frame.val           <= {NSIG{mos_pkg::ERR_VALUE}}; // see RULE5
          if (hold_mode == mos_pkg::HOLD_INF) begin
            held_frame <= '{intensity_err: 1'b0, range_err: 1'b0, val: last_good}; // see RULE6
          end else if (hold_mode == mos_pkg::HOLD_COUNT && hold_cnt < hold_n) begin
            held_frame <= '{intensity_err: 1'b0, range_err: 1'b0, val: last_good}; // see RULE7
            hold_cnt   <= hold_cnt + 11'h001;
          end
        end
      end
      if (bus_req.wr && bus_req.addr == mos_pkg::ADDR_HOLD) hold_cnt <= 11'h000; // see RULE23
    end
  end

  // decimation counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dec_cnt <= 22'h000000;
    end else if (bus_req.wr && (bus_req.addr == mos_pkg::ADDR_DEC_DIV ||
                                bus_req.addr == mos_pkg::ADDR_DEC_EN)) begin
      dec_cnt <= 22'h000000; // see RULE23
    end else if (held_stb) begin
      if (dec_cnt >= dec_div - 22'h000001) dec_cnt <= 22'h000000; // see RULE4
      else dec_cnt <= dec_cnt + 22'h000001;
    end
  end

  assign dec_hit  = (dec_cnt == 22'h000000);
  assign pass_ser = held_stb && out_sel == mos_pkg::OUT_SER &&
                    (!dec_en[mos_pkg::EN_SER] || dec_hit); // see RULE3
  assign pass_net = held_stb && out_sel == mos_pkg::OUT_NET &&
                    (!dec_en[mos_pkg::EN_NET] || dec_hit); // see RULE3
  assign pass_ana = held_stb && out_sel == mos_pkg::OUT_ANA &&
                    (!dec_en[mos_pkg::EN_ANA] || dec_hit); // see RULE3

  // network signal set
  always_comb begin
    net_eff = net_sel;
    net_eff[mos_pkg::SIG_DIST1] = 1'b1; // see RULE8
    if (thickness_mode) begin
      net_eff[mos_pkg::SIG_DIST2] = 1'b1; // see RULE8
      net_eff[mos_pkg::SIG_DIFF]  = 1'b1;
    end
    if (multilayer_mode) begin
      for (int i = 0; i < NSIG; i++) begin
        if (net_sel[i]) net_eff = net_eff | diff_depend[i]; // see RULE9
      end
    end
  end

  // serial and network delivery
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ser_valid <= 1'b0;
      ser_frame <= '0;
      ser_mask  <= '0;
      net_valid <= 1'b0;
      net_frame <= '0;
      net_mask  <= '0;
    end else begin
      ser_valid <= pass_ser; // see RULE1
      net_valid <= pass_net; // see RULE1
      if (pass_ser) begin
        ser_frame <= held_frame;
        ser_mask  <= ser_sel;
      end
      if (pass_net) begin
        net_frame <= held_frame;
        net_mask  <= net_eff;
      end
    end
  end

  // analog scaling
  always_comb begin
    logic signed [63:0] v64;
    logic signed [63:0] lo;
    logic signed [63:0] hi;
    logic signed [63:0] num;
    logic signed [63:0] den;
    logic signed [63:0] q;
    lo  = 64'sh0;
    hi  = 64'sh0;
    v64 = 64'($signed(held_frame.val[dac_cfg[mos_pkg::SIG_LSB +: 3]])); // see RULE18
    if (dac_cfg[mos_pkg::SCALE_BIT]) begin
      lo = 64'(dac_min); // see RULE20
      hi = 64'(dac_max);
    end else if (thickness_mode && dac_cfg[mos_pkg::SIG_LSB +: 3] == 3'(mos_pkg::SIG_DIFF)) begin
      lo = 64'sh0; // see RULE21
      hi = 64'(span) * 64'sh2;
    end else begin
      lo = -(64'(span) / 64'sh2); // see RULE21
      hi = 64'(span) / 64'sh2;
    end
    num = v64 - lo;
    den = hi - lo;
    q   = 64'sh0;
    if (den <= 64'sh0 || num <= 64'sh0) next_dac_code = 16'h0000;
    else if (num >= den) next_dac_code = mos_pkg::DAC_FULL;
    else begin
      q = (num * $signed({48'h0, mos_pkg::DAC_FULL})) / den; // see RULE22
      next_dac_code = q[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dac_valid <= 1'b0;
      dac_code  <= 16'h0000;
      dac_span  <= mos_pkg::SPAN_5V;
    end else begin
      dac_valid <= pass_ana;
      dac_span  <= dac_cfg[mos_pkg::SPAN_LSB +: 2]; // see RULE19
      if (pass_ana) dac_code <= next_dac_code;
    end
  end

  // limit comparison
  assign cmp_v     = $signed(meas_frame.val[sw_cfg[mos_pkg::CMP_SEL_LSB +: 3]]); // see RULE13
  assign below_hit = (cmp_v < lim_lo) &&
                     sw_cfg[mos_pkg::DIR_LSB +: 2] != mos_pkg::DIR_UPPER; // see RULE14
  assign above_hit = (cmp_v > lim_hi) &&
                     sw_cfg[mos_pkg::DIR_LSB +: 2] != mos_pkg::DIR_LOWER; // see RULE14

  // switching outputs
  for (genvar g = 0; g < 2; g++) begin : gen_sw
    logic [2:0] src;
    logic [1:0] style;
    logic       hit;
    logic       active;
    logic       pin_out;
    logic       pin_oe;
    assign src   = sw_cfg[mos_pkg::SRC_LSB + g*mos_pkg::SW_STRIDE +: 3];
    assign style = sw_cfg[mos_pkg::STY_LSB + g*mos_pkg::SW_STRIDE +: 2];
    always_comb begin
      case (src)
        mos_pkg::SRC_NONE:    hit = 1'b0;
        mos_pkg::SRC_INT:     hit = meas_frame.intensity_err; // see RULE11
        mos_pkg::SRC_RNG:     hit = meas_frame.range_err;
        mos_pkg::SRC_ANY:     hit = meas_err;
        mos_pkg::SRC_BELOW:   hit = below_hit; // see RULE12
        mos_pkg::SRC_ABOVE:   hit = above_hit;
        mos_pkg::SRC_OUTSIDE: hit = below_hit | above_hit;
        default:              hit = 1'b0;
      endcase
    end
    always_ff @(posedge clk_sys) begin
      if (rst) active <= 1'b0;
      else if (out_sel != mos_pkg::OUT_SW) active <= 1'b0; // see RULE2
      else if (meas_valid) active <= hit;
    end
    assign sw_active[g] = active;
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pin_out <= 1'b0;
        pin_oe  <= 1'b0;
      end else begin
        unique case (style)
          mos_pkg::STY_HIGH: begin
            pin_out <= 1'b1; // see RULE16
            pin_oe  <= sw_active[g];
          end
          mos_pkg::STY_LOW: begin
            pin_out <= 1'b0; // see RULE16
            pin_oe  <= sw_active[g];
          end
          mos_pkg::STY_TOTEM: begin
            pin_out <= sw_active[g]; // see RULE17
            pin_oe  <= 1'b1;
          end
          mos_pkg::STY_TOTEM_N: begin
            pin_out <= ~sw_active[g]; // see RULE17
            pin_oe  <= 1'b1;
          end
        endcase
      end
    end
    assign sw_out[g] = pin_out;
    assign sw_oe[g]  = pin_oe;
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_err_in;
    meas_valid && meas_err;
  endsequence
  sequence s_held;
    held_stb;
  endsequence

  property p_none_err;
    s_err_in and (hold_mode == mos_pkg::HOLD_NONE) |=> s_held and
      (held_frame.val[0] == mos_pkg::ERR_VALUE);
  endproperty
  a_none_err: assert property (p_none_err) else $error("hold none lost error value"); // see RULE5

  property p_inf_hold;
    s_err_in and (hold_mode == mos_pkg::HOLD_INF) |=> s_held and
      (held_frame.val == $past(last_good));
  endproperty
  a_inf_hold: assert property (p_inf_hold) else $error("infinite hold not last good"); // see RULE6

  property p_cnt_hold;
    s_err_in and (hold_mode == mos_pkg::HOLD_COUNT) and (hold_cnt >= hold_n) |=>
      (held_frame.val[0] == mos_pkg::ERR_VALUE);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("hold count exceeded"); // see RULE7

  property p_div_one;
    held_stb && out_sel == mos_pkg::OUT_SER && dec_div == 22'h000001 |=> ser_valid;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divisor one dropped frame"); // see RULE4

  property p_no_dec;
    held_stb && out_sel == mos_pkg::OUT_NET && !dec_en[mos_pkg::EN_NET] |=> net_valid;
  endproperty
  a_no_dec: assert property (p_no_dec) else $error("undecimated frame dropped"); // see RULE3

  property p_net_base;
    net_valid |-> net_mask[mos_pkg::SIG_DIST1];
  endproperty
  a_net_base: assert property (p_net_base) else $error("network lacks distance one"); // see RULE8

  property p_div_restart;
    bus_req.wr && bus_req.addr == mos_pkg::ADDR_DEC_DIV |=> dec_cnt == 22'h000000;
  endproperty
  a_div_restart: assert property (p_div_restart) else $error("counter not restarted"); // see RULE23

  property p_sw_off;
    out_sel != mos_pkg::OUT_SW |=> sw_active == 2'b00;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("switch active outside mode"); // see RULE2

  property p_totem;
    !$past(rst) && $past(sw_cfg[mos_pkg::STY_LSB +: 2]) == mos_pkg::STY_TOTEM |->
      sw_oe[0] && sw_out[0] == $past(sw_active[0]);
  endproperty
  a_totem: assert property (p_totem) else $error("totem level wrong"); // see RULE17

  property p_open_high;
    !$past(rst) && $past(sw_cfg[mos_pkg::STY_LSB +: 2]) == mos_pkg::STY_HIGH |->
      sw_out[0] && sw_oe[0] == $past(sw_active[0]);
  endproperty
  a_open_high: assert property (p_open_high) else $error("open high drive wrong"); // see RULE16
endmodule : mos_output_stage

// [hw/mos_pkg.sv]
// constants and carrier types for the measurement output stage
package mos_pkg;
  localparam int NSIG = 8;
  localparam int VW   = 32;

  typedef logic [NSIG-1:0] mos_mask_t;

  typedef struct packed {
    logic                     intensity_err;
    logic                     range_err;
    logic [NSIG-1:0][VW-1:0]  val;
  } mos_frame_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mos_req_s;

  // register offsets
  localparam logic [7:0] ADDR_OUT_SEL = 8'h00;
  localparam logic [7:0] ADDR_DEC_EN  = 8'h04;
  localparam logic [7:0] ADDR_DEC_DIV = 8'h08;
  localparam logic [7:0] ADDR_HOLD    = 8'h0c;
  localparam logic [7:0] ADDR_SW_CFG  = 8'h10;
  localparam logic [7:0] ADDR_LIM_LO  = 8'h14;
  localparam logic [7:0] ADDR_LIM_HI  = 8'h18;
  localparam logic [7:0] ADDR_DAC_CFG = 8'h1c;
  localparam logic [7:0] ADDR_DAC_MIN = 8'h20;
  localparam logic [7:0] ADDR_DAC_MAX = 8'h24;
  localparam logic [7:0] ADDR_SPAN    = 8'h28;
  localparam logic [7:0] ADDR_SER_SEL = 8'h2c;
  localparam logic [7:0] ADDR_NET_SEL = 8'h30;
  localparam logic [7:0] ADDR_SER_SEQ = 8'h34;
  localparam logic [7:0] ADDR_NET_SEQ = 8'h38;
  localparam logic [7:0] ADDR_STATUS  = 8'h3c;

  // output selector codes
  localparam logic [2:0] OUT_NONE = 3'h0;
  localparam logic [2:0] OUT_SER  = 3'h1;
  localparam logic [2:0] OUT_NET  = 3'h2;
  localparam logic [2:0] OUT_ANA  = 3'h3;
  localparam logic [2:0] OUT_SW   = 3'h4;

  // decimation enable bits
  localparam int EN_SER = 0;
  localparam int EN_ANA = 1;
  localparam int EN_NET = 2;

  // error hold field
  localparam int         HOLD_MODE_LSB = 16;
  localparam logic [1:0] HOLD_NONE     = 2'h0;
  localparam logic [1:0] HOLD_INF      = 2'h1;
  localparam logic [1:0] HOLD_COUNT    = 2'h2;
  localparam logic [10:0] HOLD_MAX     = 11'h400;

  // switching configuration fields
  localparam int SRC_LSB     = 0;
  localparam int STY_LSB     = 8;
  localparam int SW_STRIDE   = 4;
  localparam int DIR_LSB     = 16;
  localparam int CMP_SEL_LSB = 20;
  localparam logic [2:0] SRC_NONE    = 3'h0;
  localparam logic [2:0] SRC_INT     = 3'h1;
  localparam logic [2:0] SRC_RNG     = 3'h2;
  localparam logic [2:0] SRC_ANY     = 3'h3;
  localparam logic [2:0] SRC_BELOW   = 3'h4;
  localparam logic [2:0] SRC_ABOVE   = 3'h5;
  localparam logic [2:0] SRC_OUTSIDE = 3'h6;
  localparam logic [1:0] STY_HIGH    = 2'h0;
  localparam logic [1:0] STY_LOW     = 2'h1;
  localparam logic [1:0] STY_TOTEM   = 2'h2;
  localparam logic [1:0] STY_TOTEM_N = 2'h3;
  localparam logic [1:0] DIR_LOWER   = 2'h0;
  localparam logic [1:0] DIR_UPPER   = 2'h1;
  localparam logic [1:0] DIR_BOTH    = 2'h2;

  // analog configuration fields
  localparam int SIG_LSB   = 0;
  localparam int SPAN_LSB  = 4;
  localparam int SCALE_BIT = 8;
  localparam logic [1:0] SPAN_5V  = 2'h0;
  localparam logic [1:0] SPAN_10V = 2'h1;
  localparam logic [1:0] SPAN_MA  = 2'h2;

  // signal indices and limits
  localparam int SIG_DIST1 = 0;
  localparam int SIG_DIST2 = 1;
  localparam int SIG_DIFF  = 2;
  localparam logic [21:0] DIV_MAX   = 22'h2dc6c0;
  localparam logic [31:0] BOUND_MAX = 32'h0020c2b8;
  localparam logic [31:0] ERR_VALUE = 32'h80000000;
  localparam logic [15:0] DAC_FULL  = 16'hffff;

  // reset values
  localparam logic [21:0] DIV_RST  = 22'h000001;
  localparam logic [31:0] SPAN_RST = 32'h00002710;
  localparam logic [31:0] DMAX_RST = 32'h00002710;
endpackage : mos_pkg

// [tb/mos_far_side.sv]
// far side model: switch input receiver and stream counters
`timescale 1ns/1ps
module mos_far_side #(
  parameter logic [1:0] PULL = 2'b10
) (
  // clock
  input  wire logic       clk_sys,
  // device outputs
  input  wire logic       ser_valid,
  input  wire logic       net_valid,
  input  wire logic       dac_valid,
  input  wire logic [1:0] sw_out,
  input  wire logic [1:0] sw_oe,
  // observed levels and counts
  output logic [1:0]      pin,
  output int              n_ser,
  output int              n_net,
  output int              n_dac
);
  // undriven pin settles to its pull resistor level
  int c_ser = 0;
  int c_net = 0;
  int c_dac = 0;
  assign pin = (sw_oe & sw_out) | (~sw_oe & PULL);
  assign n_ser = c_ser;
  assign n_net = c_net;
  assign n_dac = c_dac;
  always @(posedge clk_sys) begin
    c_ser <= c_ser + int'(ser_valid);
    c_net <= c_net + int'(net_valid);
    c_dac <= c_dac + int'(dac_valid);
  end
endmodule : mos_far_side

// [tb/testbench.sv]
// self-checking bench for the measurement output stage
`timescale 1ns/1ps
module testbench;
  logic                                   clk_sys = 1'b0;
  logic                                   rst = 1'b1;
  mos_pkg::mos_req_s                      bus_req = '0;
  logic                                   meas_valid = 1'b0;
  mos_pkg::mos_frame_s                    meas_frame = '0;
  logic                                   thickness_mode = 1'b0;
  logic                                   multilayer_mode = 1'b0;
  mos_pkg::mos_mask_t [mos_pkg::NSIG-1:0] diff_depend = '0;
  logic [31:0]                            bus_rdata;
  logic                                   ser_valid, net_valid, dac_valid;
  mos_pkg::mos_frame_s                    ser_frame, net_frame;
  mos_pkg::mos_mask_t                     ser_mask, net_mask;
  logic [15:0]                            dac_code;
  logic [1:0]                             dac_span, sw_out, sw_oe, pin;
  int                                     n_ser, n_net, n_dac, base;
  int                                     error_cnt = 0;
  int                                     samples_checked = 0;
  // rows: style, error, expected pin level, expected enable
  localparam logic [4:0] ROWS [8] = '{5'h07, 5'h00, 5'h0d, 5'h08, 5'h17, 5'h11, 5'h1d, 5'h1b};

  mos_output_stage dut (.clk_sys, .rst, .bus_req, .bus_rdata, .meas_valid, .meas_frame,
    .thickness_mode, .multilayer_mode, .diff_depend, .ser_valid, .ser_frame, .ser_mask,
    .net_valid, .net_frame, .net_mask, .dac_valid, .dac_code, .dac_span, .sw_out, .sw_oe);
  mos_far_side far (.clk_sys, .ser_valid, .net_valid, .dac_valid, .sw_out, .sw_oe, .pin,
    .n_ser, .n_net, .n_dac);

  always #10 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(posedge clk_sys);
    chk(bus_rdata, e);
  endtask : rd
  task automatic frame(input logic [31:0] v, input logic ie, input logic re);
    @(posedge clk_sys);
    meas_frame <= '{intensity_err: ie, range_err: re, val: {mos_pkg::NSIG{v}}};
    meas_valid <= 1'b1;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : frame
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  initial begin
    #1ms;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h1);
    rd(8'h40, 32'h0);
    $display("reset test done");
    wr(8'h2c, 32'h05);
    wr(8'h00, 32'h1);
    base = n_net;
    frame(32'h1234, 1'b0, 1'b0);
    chk(32'(n_net - base), 32'h0);
    chk(ser_frame.val[0], 32'h1234);
    chk({24'h0, ser_mask}, 32'h05);
    rd(8'h34, 32'hffffff20);
    thickness_mode <= 1'b1;
    wr(8'h30, 32'h08);
    wr(8'h00, 32'h2);
    frame(32'h1, 1'b0, 1'b0);
    chk({24'h0, net_mask}, 32'h0f);
    thickness_mode <= 1'b0;
    multilayer_mode <= 1'b1;
    diff_depend[3] <= 8'h30;
    frame(32'h2, 1'b0, 1'b0);
    chk({24'h0, net_mask}, 32'h39);
    chk(net_frame.val[0], 32'h2);
    $display("selector test done");
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h3);
    base = n_ser;
    repeat (6) frame(32'h3, 1'b0, 1'b0);
    chk(32'(n_ser - base), 32'h2);
    wr(8'h04, 32'h0);
    base = n_ser;
    repeat (3) frame(32'h3, 1'b0, 1'b0);
    chk(32'(n_ser - base), 32'h3);
    $display("decimation test done");
    frame(32'h55, 1'b0, 1'b0);
    frame(32'h66, 1'b1, 1'b0);
    chk(ser_frame.val[0], mos_pkg::ERR_VALUE);
    wr(8'h0c, 32'h00020002);
    frame(32'h77, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      frame(32'h88, 1'b0, 1'b1);
      chk(ser_frame.val[0], (i < 2) ? 32'h77 : mos_pkg::ERR_VALUE);
    end
    wr(8'h0c, 32'h00010000);
    frame(32'h99, 1'b0, 1'b0);
    repeat (3) frame(32'h11, 1'b1, 1'b0);
    chk(ser_frame.val[0], 32'h99);
    $display("hold test done");
    wr(8'h00, 32'h4);
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, {22'h0, ROWS[i][4:3], 8'h01});
      frame(32'h0, ROWS[i][2], 1'b0);
      chk({30'h0, pin[0], sw_oe[0]}, {30'h0, ROWS[i][1:0]});
    end
    chk({30'h0, pin[1], sw_oe[1]}, 32'h2);
    wr(8'h14, 32'd100);
    wr(8'h18, 32'd200);
    wr(8'h10, 32'h00020206);
    frame(32'd50, 1'b0, 1'b0);
    chk({31'h0, pin[0]}, 32'h1);
    frame(32'd150, 1'b0, 1'b0);
    chk({31'h0, pin[0]}, 32'h0);
    frame(32'd250, 1'b0, 1'b0);
    chk({31'h0, pin[0]}, 32'h1);
    wr(8'h10, 32'h00000206);
    frame(32'd250, 1'b0, 1'b0);
    chk({31'h0, pin[0]}, 32'h0);
    $display("switching test done");
    wr(8'h00, 32'h3);
    wr(8'h1c, 32'h10);
    base = n_dac;
    frame(32'd6000, 1'b0, 1'b0);
    chk({16'h0, dac_code}, 32'hffff);
    chk({30'h0, dac_span}, 32'h1);
    frame(-32'sd6000, 1'b0, 1'b0);
    chk({16'h0, dac_code}, 32'h0);
    chk(32'(n_dac - base), 32'h2);
    wr(8'h20, 32'h7fffffff);
    rd(8'h20, mos_pkg::BOUND_MAX);
    $display("analog test done");
    give_verdict();
  end
endmodule : testbench
